// file: bench/relay_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module relay_contacts (
	input wire logic make_sel,
	input wire logic break_sel,
	output logic on_make
);
	// Both or neither contact shows as unknown
	assign on_make = make_sel ^ break_sel ? make_sel : 1'bx;
endmodule // relay_contacts
`default_nettype wire

// file: bench/relay_output_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module relay_output_logic_tb_top;
	logic CLOCK = 0, RST = 1, CFG_LOAD = 0, CTRL_IN = 0, MAKE_SEL, BREAK_SEL, CTRL_STATE, on_make, m;
	logic [2:0] CFG_OUT_TYPE = 3'h1, OUT_TYPE;
	logic [1:0] CFG_POLARITY = 2'h0;
	logic [15:0] RATE = 16'h0003;
	// Rows: type, polarity, control, expected make
	logic [6:0] rows [8] = '{7'h13, 7'h10, 7'h22, 7'h21, 7'h16, 7'h27, 7'h02, 7'h04};
	int fail_count = 0, checked = 0, cyc = 0, n;
	always #10 CLOCK = ~CLOCK;
	relay_output_logic #(.TICK_CYCLES(5)) i_dut (.CLOCK, .RST, .CFG_LOAD, .CFG_OUT_TYPE, .CFG_POLARITY,
		.CFG_TOGGLE_RATE_MS(RATE), .CTRL_IN, .MAKE_SEL, .BREAK_SEL, .OUT_TYPE, .CTRL_STATE);
	relay_contacts i_relay (.make_sel(MAKE_SEL), .break_sel(BREAK_SEL), .on_make);
	task automatic cmp(input logic [7:0] got, exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic [2:0] t, input logic [1:0] p);
		@(negedge CLOCK) {CFG_OUT_TYPE, CFG_POLARITY, CFG_LOAD} = {t, p, 1'b1};
		@(negedge CLOCK) CFG_LOAD = 0;
	endtask
	task automatic drive(input logic c);
		CTRL_IN = c;
		repeat (8) @(negedge CLOCK);
	endtask
	task automatic wchg;
		m = on_make;
		n = 0;
		do @(negedge CLOCK) n++; while (on_make === m && n < 200);
	endtask
	task automatic end_of_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge CLOCK) if (++cyc == 20000) begin
		fail_count++;
		end_of_test;
	end
	initial begin
		repeat (2) @(negedge CLOCK);
		RST = 0;
		cmp(OUT_TYPE, 3'h1);
		foreach (rows[i]) begin
			cfg(rows[i][6:4], rows[i][3:2]);
			drive(rows[i][1]);
			cmp(on_make, rows[i][0]);
		end
		drive(0);
		RST = 1;
		repeat (2) @(negedge CLOCK);
		RST = 0;
		cmp(OUT_TYPE, 3'h1);
		cmp(on_make, 1'b0);
		cfg(3'h3, 2'h0);
		for (int i = 0; i < 3; i++) begin
			drive(i != 1);
			cmp(on_make, i != 2);
		end
		cfg(3'h4, 2'h0);
		drive(1);
		m = on_make;
		drive(0);
		cmp(on_make, !m);
		drive(1);
		cmp(on_make, !m);
		cfg(3'h1, 2'h2);
		drive(0);
		m = on_make;
		drive(1);
		cmp(CTRL_STATE, !m);
		cmp(on_make, !m);
		drive(0);
		cmp(on_make, !m);
		cfg(3'h5, 2'h0);
		// First change may come from the type switch itself
		repeat (3) wchg;
		cmp(8'(n), 8'h0f);
		RATE = 16'h0002;
		cfg(3'h5, 2'h0);
		repeat (2) wchg;
		cmp(8'(n), 8'h0a);
		end_of_test;
	end
endmodule // relay_output_logic_tb_top
`default_nettype wire

// file: bench/relay_props.sv
`timescale 1ns/1ps
`default_nettype none
module relay_props (
	input wire logic CLOCK, RST, CFG_LOAD, CTRL_IN, MAKE_SEL, BREAK_SEL, CTRL_STATE,
	input wire logic [1:0] CFG_POLARITY,
	input wire logic [2:0] OUT_TYPE
);
	logic [1:0] pol_q;
	logic [4:0] rst_hist = 5'h1f;
	always @(posedge CLOCK) pol_q <= RST ? 2'h0 : CFG_LOAD ? CFG_POLARITY : pol_q;
	// Reset seen in any of the last five cycles
	always @(posedge CLOCK) rst_hist <= {rst_hist[3:0], RST};
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	one_contact_a: assert property (BREAK_SEL != MAKE_SEL) else $error("contacts");
	reset_type_a: assert property ($past(RST) |-> OUT_TYPE == 3'h1 && !MAKE_SEL) else $error("reset");
	normal_out_a: assert property (!$past(RST) && $past(OUT_TYPE) == 3'h1 |-> MAKE_SEL == $past(CTRL_STATE))
		else $error("normal");
	inverse_out_a: assert property (!$past(RST) && $past(OUT_TYPE) == 3'h2 |-> MAKE_SEL != $past(CTRL_STATE))
		else $error("inverse");
	off_break_a: assert property (!$past(RST) && $past(OUT_TYPE) == 3'h0 |-> !MAKE_SEL) else $error("off");
	latch_flip_a: assert property ($rose(CTRL_STATE) && OUT_TYPE == 3'h3 ##1 OUT_TYPE == 3'h3 |=> $changed(MAKE_SEL))
		else $error("latch");
	inv_latch_a: assert property ($fell(CTRL_STATE) && OUT_TYPE == 3'h4 ##1 OUT_TYPE == 3'h4 |=> $changed(MAKE_SEL))
		else $error("inverse latch");
	pol_pass_a: assert property (rst_hist == 5'h00 && $past(pol_q) != 2'h2 |->
		CTRL_STATE == ($past(CTRL_IN, 3) ^ ($past(pol_q) == 2'h1))) else $error("polarity");
	pol_toggle_a: assert property (rst_hist == 5'h00 && $past(pol_q) == 2'h2 && $past(pol_q, 2) == 2'h2 |->
		CTRL_STATE == ($past(CTRL_STATE) ^ ($past(CTRL_IN, 4) && !$past(CTRL_IN, 5)))) else $error("toggle");
	cover property (OUT_TYPE == 3'h5 && $changed(MAKE_SEL));
	cover property (OUT_TYPE == 3'h3 && $changed(MAKE_SEL));
	cover property (pol_q == 2'h2 && $changed(CTRL_STATE));
endmodule // relay_props
bind relay_output_logic relay_props i_props (.CLOCK, .RST, .CFG_LOAD, .CTRL_IN, .MAKE_SEL, .BREAK_SEL,
	.CTRL_STATE, .CFG_POLARITY, .OUT_TYPE);
`default_nettype wire

// file: verilog/input_polarity.v
`timescale 1ns/1ps
`default_nettype none
`include "relay_out_consts.vh"

module input_polarity (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Configuration
	input wire [1:0] polarity,
	// Input and conditioned result
	input wire raw_in,
	output reg cond_out
);

	reg raw_prev_q;
	reg toggle_q;

	always @(posedge clk) begin
		if (rst) begin
			raw_prev_q <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			raw_prev_q <= raw_in;
			if (raw_in && !raw_prev_q) begin
				toggle_q <= ~toggle_q; // R08
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			cond_out <= 1'b0;
		end else begin
			case (polarity) // R07
			`POL_NORMAL: cond_out <= raw_in;
			`POL_INVERSE: cond_out <= ~raw_in;
			`POL_TOGGLE: cond_out <= toggle_q;
			default: cond_out <= raw_in;
			endcase
		end
	end

endmodule // input_polarity
`default_nettype wire

// file: verilog/relay_out_consts.vh
`ifndef RELAY_OUT_CONSTS_VH
`define RELAY_OUT_CONSTS_VH

// ==========================================
// Output response type codes
`define OUT_TYPE_DISABLED 3'h0
`define OUT_TYPE_NORMAL 3'h1
`define OUT_TYPE_INVERSE 3'h2
`define OUT_TYPE_LATCHED 3'h3
`define OUT_TYPE_INV_LATCHED 3'h4
`define OUT_TYPE_TOGGLE 3'h5
`define OUT_TYPE_RESET `OUT_TYPE_NORMAL

// ==========================================
// Input polarity codes
`define POL_NORMAL 2'h0
`define POL_INVERSE 2'h1
`define POL_TOGGLE 2'h2

// ==========================================
// Timing
`define CLOCK_HZ 50000000
`define TICK_MS 1
`define TICK_CYCLES ((`CLOCK_HZ / 1000) * `TICK_MS)
`define TOGGLE_RATE_MS_RESET 16'h01f4

`endif

// file: verilog/relay_output_logic.v
// Functional notes
// R01 - Relay has two positions; common joins either break or make contact.
// R02 - After reset the response type is normal.
// R03 - Normal: make while control ON, break while OFF.
// R04 - Latched: flip position on each OFF-to-ON control transition.
// R05 - Inverse latched: flip position on each ON-to-OFF control transition.
// R06 - Toggle: alternate position every toggle-rate milliseconds, default 500.
// R07 - Input polarity codes: 0 pass, 1 invert, 2 toggle.
// R08 - Toggle polarity inverts state on each rising raw input.
// R09 - Inverse: break while control ON, make while OFF.
// R10 - Type codes 0..5; disabled rests on break contact.
`timescale 1ns/1ps
`default_nettype none
`include "relay_out_consts.vh"

module relay_output_logic #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter RATE_W = 16
) (
	// Clock and reset
	input wire CLOCK,
	input wire RST,
	// Configuration
	input wire CFG_LOAD,
	input wire [2:0] CFG_OUT_TYPE,
	input wire [1:0] CFG_POLARITY,
	input wire [RATE_W-1:0] CFG_TOGGLE_RATE_MS,
	// Control input from pin
	input wire CTRL_IN,
	// Relay driver
	output reg MAKE_SEL,
	output wire BREAK_SEL,
	// Status
	output wire [2:0] OUT_TYPE,
	output wire CTRL_STATE
);

	// ==========================================
	// Configuration registers
	reg [2:0] type_q;
	reg [2:0] type_d;
	reg [1:0] pol_q;
	reg [1:0] pol_d;
	reg [RATE_W-1:0] rate_q;
	reg [RATE_W-1:0] rate_d;

	always @* begin
		type_d = type_q;
		pol_d = pol_q;
		rate_d = rate_q;
		if (CFG_LOAD) begin
			type_d = CFG_OUT_TYPE;
			pol_d = CFG_POLARITY;
			rate_d = CFG_TOGGLE_RATE_MS;
		end
	end

	always @(posedge CLOCK) begin
		if (RST) begin
			type_q <= `OUT_TYPE_RESET; // R02
			pol_q <= `POL_NORMAL;
			rate_q <= `TOGGLE_RATE_MS_RESET; // R06
		end else begin
			type_q <= type_d;
			pol_q <= pol_d;
			rate_q <= rate_d;
		end
	end

	assign OUT_TYPE = type_q;

	// ==========================================
	// Input synchroniser
	reg sync1_q;
	reg sync2_q;

	always @(posedge CLOCK) begin
		if (RST) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= CTRL_IN;
			sync2_q <= sync1_q;
		end
	end

	// ==========================================
	// Polarity stage
	wire ctrl;

	input_polarity u_pol (
		.clk(CLOCK),
		.rst(RST),
		.polarity(pol_q),
		.raw_in(sync2_q),
		.cond_out(ctrl)
	);

	assign CTRL_STATE = ctrl;

	reg ctrl_prev_q;

	always @(posedge CLOCK) begin
		if (RST) begin
			ctrl_prev_q <= 1'b0;
		end else begin
			ctrl_prev_q <= ctrl;
		end
	end

	wire rise = ctrl && !ctrl_prev_q;
	wire fall = !ctrl && ctrl_prev_q;

	// ==========================================
	// Millisecond tick and toggle timer
	reg [31:0] tick_cnt_q;
	reg [31:0] tick_cnt_d;
	reg [RATE_W-1:0] ms_cnt_q;
	reg [RATE_W-1:0] ms_cnt_d;
	wire tick = (tick_cnt_q == TICK_CYCLES - 1);
	wire in_toggle = (type_q == `OUT_TYPE_TOGGLE);
	// Rate 0 runs as 1 ms
	wire period_done = tick && (ms_cnt_q + 1'b1 >= rate_q);

	always @* begin
		tick_cnt_d = tick_cnt_q + 32'h1;
		ms_cnt_d = ms_cnt_q;
		if (!in_toggle) begin
			// Timer restarts on each entry to toggle
			tick_cnt_d = 32'h0;
			ms_cnt_d = {RATE_W{1'b0}};
		end else if (period_done) begin
			tick_cnt_d = 32'h0;
			ms_cnt_d = {RATE_W{1'b0}};
		end else if (tick) begin
			tick_cnt_d = 32'h0;
			ms_cnt_d = ms_cnt_q + 1'b1;
		end
	end

	always @(posedge CLOCK) begin
		if (RST) begin
			tick_cnt_q <= 32'h0;
			ms_cnt_q <= {RATE_W{1'b0}};
		end else begin
			tick_cnt_q <= tick_cnt_d;
			ms_cnt_q <= ms_cnt_d;
		end
	end

	// ==========================================
	// Latch state
	reg latch_q;
	reg latch_d;

	always @* begin
		latch_d = latch_q;
		case (type_q)
		`OUT_TYPE_LATCHED: begin
			if (rise) begin
				latch_d = ~latch_q; // R04
			end
		end
		`OUT_TYPE_INV_LATCHED: begin
			if (fall) begin
				latch_d = ~latch_q; // R05
			end
		end
		`OUT_TYPE_TOGGLE: begin
			if (period_done) begin
				latch_d = ~latch_q; // R06
			end
		end
		default: begin
			latch_d = latch_q;
		end
		endcase
	end

	always @(posedge CLOCK) begin
		if (RST) begin
			latch_q <= 1'b0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// ==========================================
	// Contact selection
	reg make_d;

	always @* begin
		case (type_q) // R10
		`OUT_TYPE_DISABLED: begin
			make_d = 1'b0; // R10
		end
		`OUT_TYPE_NORMAL: begin
			make_d = ctrl; // R03
		end
		`OUT_TYPE_INVERSE: begin
			make_d = ~ctrl; // R09
		end
		`OUT_TYPE_LATCHED: begin
			make_d = latch_q;
		end
		`OUT_TYPE_INV_LATCHED: begin
			make_d = latch_q;
		end
		`OUT_TYPE_TOGGLE: begin
			make_d = latch_q;
		end
		default: begin
			make_d = 1'b0;
		end
		endcase
	end

	always @(posedge CLOCK) begin
		if (RST) begin
			MAKE_SEL <= 1'b0;
		end else begin
			MAKE_SEL <= make_d;
		end
	end

	// Exactly one contact joined to common
	assign BREAK_SEL = ~MAKE_SEL; // R01

endmodule // relay_output_logic
`default_nettype wire
